// [taa_pkg.sv]
// Shared constants, types and states of the tally address modifier
package taa_pkg;

  localparam int ADDR_W = 18;
  localparam int TALLY_W = 12;
  localparam int TAG_W = 6;
  localparam int CPOS_W = 3;

  // Pointer word: address, tally, then the tag (or delta / character position)
  typedef struct packed {
    logic [ADDR_W-1:0]  addr;
    logic [TALLY_W-1:0] tally;
    logic [TAG_W-1:0]   tag;
  } taa_word_t;

  // Memory request carried towards main memory
  typedef struct packed {
    logic              req;
    logic              we;
    logic [ADDR_W-1:0] addr;
    taa_word_t         wdata;
  } taa_mreq_t;

  // Modifier classes in the upper two tag bits
  localparam logic [1:0] TM_R = 2'h0;
  localparam logic [1:0] TM_REG_PTR = 2'h1;
  localparam logic [1:0] TM_IT = 2'h2;
  localparam logic [1:0] TM_PTR_IDX = 2'h3;

  // Tally variation designators
  localparam logic [3:0] TD_PLAIN = 4'h9;
  localparam logic [3:0] TD_STEP_UP = 4'he;
  localparam logic [3:0] TD_STEP_DOWN = 4'hc;
  localparam logic [3:0] TD_SEQ_CHAR = 4'ha;
  localparam logic [3:0] TD_CHAR_PTR = 4'h8;
  localparam logic [3:0] TD_STRIDE = 4'hb;
  localparam logic [3:0] TD_TRAP = 4'h0;
  localparam logic [3:0] TD_UP_CHAIN = 4'hf;
  localparam logic [3:0] TD_DOWN_CHAIN = 4'hd;

  // Whole tag codes with no register (octal 20, 60, 51)
  localparam logic [TAG_W-1:0] TAG_REG_PTR_NONE = 6'h10;
  localparam logic [TAG_W-1:0] TAG_PTR_IDX_NONE = 6'h30;
  localparam logic [TAG_W-1:0] TAG_IT_PLAIN = 6'h29;

  localparam logic [CPOS_W-1:0] CPOS_LAST = 3'h5;
  localparam logic [CPOS_W-1:0] CPOS_FIRST = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 18'h00001;
  localparam logic [TALLY_W-1:0] TALLY_ONE = 12'h001;
  localparam logic [TALLY_W-1:0] TALLY_ZERO = 12'h000;

  // Register map (byte addresses)
  localparam int APB_AW = 12;
  localparam logic [APB_AW-1:0] OFF_STAT = 12'h000;
  localparam logic [APB_AW-1:0] OFF_MASK = 12'h004;
  localparam logic [APB_AW-1:0] OFF_CTRL = 12'h008;
  localparam logic [APB_AW-1:0] OFF_EA = 12'h00c;

  // Status / mask bit positions
  localparam int ST_W = 3;
  localparam int SB_DONE = 0;
  localparam int SB_RUNOUT = 1;
  localparam int SB_FAULT = 2;
  localparam logic [ST_W-1:0] MASK_RST = 3'h0;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam int CB_EN = 0;

  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_EVAL  = 3'b001,
    S_FETCH = 3'b010,
    S_MOD   = 3'b011,
    S_WBACK = 3'b100,
    S_DONE  = 3'b101
  } taa_state_t;

endpackage

// [taa_ptr_update.sv]
// Pointer word update for one tally variation
`timescale 1ns/100ps
module taa_ptr_update
  import taa_pkg::*;
(
  // Variation and fetched pointer
  input  wire logic [3:0]          td,
  input  wire taa_pkg::taa_word_t  word,
  // Update result
  output taa_pkg::taa_word_t       nword,
  output logic [taa_pkg::ADDR_W-1:0] ea,
  output logic [taa_pkg::CPOS_W-1:0] cpos,
  output logic                     cvalid,
  output logic                     wr,
  output logic                     chain,
  output logic                     fault
);
  wire [CPOS_W-1:0] cur_cpos = word.tag[CPOS_W-1:0];
  wire              cpos_wrap = (cur_cpos == CPOS_LAST);

  always_comb begin
    nword = word;
    ea = word.addr;
    cpos = cur_cpos;
    cvalid = 1'b0;
    wr = 1'b0;
    chain = 1'b0;
    fault = 1'b0;
    case (td) // R16
      TD_PLAIN: begin
        // Tag of the pointer is never looked at R17
        ea = word.addr; // R03
      end
      TD_STEP_UP, TD_UP_CHAIN: begin
        // Address given out before the step R04 R13
        nword.addr = word.addr + ADDR_ONE;
        nword.tally = word.tally - TALLY_ONE; // R19
        wr = 1'b1;
        chain = (td == TD_UP_CHAIN); // R13
      end
      TD_STEP_DOWN, TD_DOWN_CHAIN: begin
        nword.addr = word.addr - ADDR_ONE; // R06 R15
        nword.tally = word.tally + TALLY_ONE; // R07
        ea = nword.addr; // R06
        wr = 1'b1;
        chain = (td == TD_DOWN_CHAIN); // R15
      end
      TD_SEQ_CHAR: begin
        cvalid = 1'b1; // R08
        nword.tally = word.tally - TALLY_ONE; // R09
        nword.tag[CPOS_W-1:0] = cpos_wrap ? CPOS_FIRST : cur_cpos + 3'h1; // R09
        nword.addr = cpos_wrap ? word.addr + ADDR_ONE : word.addr; // R09
        wr = 1'b1;
      end
      TD_CHAR_PTR: begin
        // No write: address and position stay as stored R10
        cvalid = 1'b1;
      end
      TD_STRIDE: begin
        nword.addr = word.addr + {{(ADDR_W-TAG_W){1'b0}}, word.tag}; // R11
        nword.tally = word.tally - TALLY_ONE; // R11
        wr = 1'b1;
      end
      default: begin
        // Trap, and undefined designators treated alike R12
        fault = 1'b1;
      end
    endcase
  end
endmodule

// [taa_modifier.sv]
// Effective-address former for pointer-word (tally) modification
// What this block does
// R01: Tag 20 fetches the pointer at the address field, adding no offset.
// R02: Tag 60 fetches the pointer at the address field and saves zero index.
// R03: Plain variant does exactly one pointer fetch; its address is the result.
// R04: Step-up gives the address, then adds one to address, subtracts tally.
// R05: Tally reaching zero on an update sets the runout indicator.
// R06: Step-down decrements address, increments tally, then gives new address.
// R07: Step-down from 4096-j tally runs out on the jth reference by wrap.
// R08: Character sequencing gives the address and selects a 6-bit character.
// R09: Sequencing steps position, decrements tally; position 5 wraps, address steps.
// R10: Fixed character selects a character and leaves the pointer unchanged.
// R11: Stride gives the address, then adds delta and decrements tally.
// R12: Trap variant abandons operand forming and forces a fault transfer.
// R13: Step-up-and-chain updates like step-up then follows the pointed word.
// R14: Software never follows a chaining pointer with index-adder forms.
// R15: Step-down-and-chain updates first, then continues like step-up-and-chain.
// R16: Variation designators decode to their fixed four-bit codes.
// R17: Plain variant ignores the fetched word's tag, ending the chain.
// R18: Trap goes to a fixed fault location and leaves the pointer alone.
// R19: Tally wraps modulo 4096; updated pointers are written back before done.
`timescale 1ns/100ps
module taa_modifier
  import taa_pkg::*;
#(
  parameter logic [taa_pkg::ADDR_W-1:0] FAULT_LOC = 18'h00000
)(
  // Clock and reset
  input  wire logic                         mclk,
  input  wire logic                         rst,
  // Instruction side
  input  wire logic                         inst_valid,
  input  wire logic [taa_pkg::ADDR_W-1:0]   inst_y,
  input  wire logic [taa_pkg::TAG_W-1:0]    inst_tag,
  output logic                              inst_ready,
  output logic                              res_valid,
  output logic [taa_pkg::ADDR_W-1:0]        res_ea,
  output logic [taa_pkg::CPOS_W-1:0]        res_char,
  output logic                              res_char_valid,
  output logic                              res_fault,
  output logic                              tally_runout,
  // Main memory
  output taa_pkg::taa_mreq_t                mem_out,
  input  wire logic                         mem_ack,
  input  wire taa_pkg::taa_word_t           mem_rdata,
  // APB register port
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [taa_pkg::APB_AW-1:0]   paddr,
  input  wire logic [31:0]                  pwdata,
  output logic [31:0]                       prdata,
  output logic                              pready,
  output logic                              pslverr,
  output logic                              irq
);
  import taa_pkg::*;

  taa_state_t        state_r;
  logic [ADDR_W-1:0] cur_y_r;
  logic [TAG_W-1:0]  cur_tag_r;
  logic [ADDR_W-1:0] saved_idx_r;
  taa_word_t         word_r;
  taa_mreq_t         mreq_r;
  logic              inst_ready_r;
  logic              res_valid_r;
  logic [ADDR_W-1:0] ea_r;
  logic [CPOS_W-1:0] char_r;
  logic              char_valid_r;
  logic              fault_r;
  logic [ST_W-1:0]   stat_r;
  logic [ST_W-1:0]   stat_nxt;
  logic [ST_W-1:0]   mask_r;
  logic              en_r;
  logic              irq_r;
  logic [31:0]       prdata_r;
  logic              pready_r;
  logic              pslverr_r;

  taa_word_t         upd_word;
  logic [ADDR_W-1:0] upd_ea;
  logic [CPOS_W-1:0] upd_cpos;
  logic              upd_cvalid;
  logic              upd_wr;
  logic              upd_chain;
  logic              upd_fault;

  wire [1:0] cur_tm = cur_tag_r[TAG_W-1:4];
  wire [3:0] cur_td = cur_tag_r[3:0];

  taa_ptr_update taa_ptr_update_i (
    .td     (cur_td),
    .word   (word_r),
    .nword  (upd_word),
    .ea     (upd_ea),
    .cpos   (upd_cpos),
    .cvalid (upd_cvalid),
    .wr     (upd_wr),
    .chain  (upd_chain),
    .fault  (upd_fault)
  );

  // Events and bus decode
  wire in_mod = (state_r == S_MOD);
  wire take_inst = (state_r == S_IDLE) && inst_valid && inst_ready_r;
  wire ev_runout = in_mod && upd_wr && (upd_word.tally == TALLY_ZERO); // R05 R07
  wire ev_fault = in_mod && upd_fault; // R12
  wire ev_done = (state_r == S_DONE);
  wire [ST_W-1:0] ev_set = ST_W'({ev_fault, ev_runout, ev_done});
  wire apb_setup = psel && !penable;
  wire apb_acc = psel && penable && pready_r;
  wire hit_stat = (paddr == OFF_STAT);
  wire hit_mask = (paddr == OFF_MASK);
  wire hit_ctrl = (paddr == OFF_CTRL);
  wire hit_ea = (paddr == OFF_EA);
  wire hit_any = hit_stat || hit_mask || hit_ctrl || hit_ea;
  wire rd_clr = apb_acc && !pwrite && hit_stat;
  wire [31:0] rd_mux = hit_stat ? {{(32-ST_W){1'b0}}, stat_r} :
                       hit_mask ? {{(32-ST_W){1'b0}}, mask_r} :
                       hit_ctrl ? {31'h0, en_r} :
                       hit_ea   ? {{(32-ADDR_W){1'b0}}, ea_r} : 32'h0;

  // Clear only what the read reported, so an event in the setup cycle survives; set wins
  always_comb begin
    stat_nxt = (stat_r & ~(rd_clr ? prdata_r[ST_W-1:0] : {ST_W{1'b0}})) | ev_set;
  end

  // Sequencer
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_r <= S_IDLE;
      cur_y_r <= '0;
      cur_tag_r <= '0;
      saved_idx_r <= '0;
      word_r <= '0;
      mreq_r <= '0;
      inst_ready_r <= 1'b0;
      res_valid_r <= 1'b0;
      ea_r <= '0;
      char_r <= '0;
      char_valid_r <= 1'b0;
      fault_r <= 1'b0;
    end else begin
      res_valid_r <= 1'b0;
      case (state_r)
        S_IDLE: begin
          inst_ready_r <= en_r;
          if (take_inst) begin
            inst_ready_r <= 1'b0;
            cur_y_r <= inst_y;
            cur_tag_r <= inst_tag;
            saved_idx_r <= '0;
            state_r <= S_EVAL;
          end
        end
        S_EVAL: begin
          if (cur_tm == TM_R) begin
            // Chain ends on a register form; every register form is served as the no-register one
            ea_r <= cur_y_r + saved_idx_r;
            char_valid_r <= 1'b0;
            fault_r <= 1'b0;
            state_r <= S_DONE;
          end else begin
            mreq_r.req <= 1'b1; // R01 R02
            mreq_r.we <= 1'b0;
            mreq_r.addr <= cur_y_r; // R01
            if (cur_tm == TM_PTR_IDX) begin
              saved_idx_r <= '0; // R02
            end
            state_r <= S_FETCH;
          end
        end
        S_FETCH: begin
          if (mem_ack) begin
            mreq_r.req <= 1'b0;
            word_r <= mem_rdata;
            if (cur_tm == TM_IT) begin
              state_r <= S_MOD; // R03
            end else begin
              cur_y_r <= mem_rdata.addr;
              cur_tag_r <= mem_rdata.tag;
              state_r <= S_EVAL;
            end
          end
        end
        S_MOD: begin
          ea_r <= upd_fault ? FAULT_LOC : upd_ea; // R18
          char_r <= upd_cpos; // R08
          char_valid_r <= upd_cvalid;
          fault_r <= upd_fault; // R12
          if (upd_wr) begin
            mreq_r.req <= 1'b1; // R19
            mreq_r.we <= 1'b1;
            mreq_r.addr <= cur_y_r;
            mreq_r.wdata <= upd_word;
            state_r <= S_WBACK;
          end else begin
            state_r <= S_DONE; // R17 R18
          end
        end
        S_WBACK: begin
          if (mem_ack) begin
            mreq_r.req <= 1'b0;
            mreq_r.we <= 1'b0;
            if (upd_chain) begin
              // Next word's own tag steers further modification
              cur_y_r <= ea_r; // R13 R15
              cur_tag_r <= TAG_REG_PTR_NONE; // R14
              char_valid_r <= 1'b0;
              state_r <= S_EVAL;
            end else begin
              state_r <= S_DONE; // R19
            end
          end
        end
        S_DONE: begin
          res_valid_r <= 1'b1;
          state_r <= S_IDLE;
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // Register file and interrupt
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stat_r <= '0;
      mask_r <= MASK_RST;
      en_r <= CTRL_EN_RST;
      irq_r <= 1'b0;
      prdata_r <= '0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      stat_r <= stat_nxt; // R05
      irq_r <= |(stat_nxt & mask_r);
      pready_r <= apb_setup;
      pslverr_r <= apb_setup && !hit_any;
      prdata_r <= apb_setup ? rd_mux : 32'h0;
      if (apb_acc && pwrite && hit_mask) begin
        mask_r <= pwdata[ST_W-1:0];
      end
      if (apb_acc && pwrite && hit_ctrl) begin
        en_r <= pwdata[CB_EN];
      end
    end
  end

  assign inst_ready = inst_ready_r;
  assign res_valid = res_valid_r;
  assign res_ea = ea_r;
  assign res_char = char_r;
  assign res_char_valid = char_valid_r;
  assign res_fault = fault_r;
  assign tally_runout = stat_r[SB_RUNOUT];
  assign mem_out = mreq_r;
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq = irq_r;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  AST_TAG20_FETCH: assert property ( // R01
    (state_r == S_EVAL && cur_tag_r == TAG_REG_PTR_NONE) |=>
      (mreq_r.req && !mreq_r.we && mreq_r.addr == $past(cur_y_r)))
    else $error("tag 20 did not fetch at address field");

  AST_TAG60_ZERO: assert property ( // R02
    (state_r == S_EVAL && cur_tag_r == TAG_PTR_IDX_NONE) |=> (saved_idx_r == '0))
    else $error("tag 60 did not save zero index");

  AST_PLAIN_END: assert property ( // R03
    (in_mod && cur_td == TD_PLAIN) |=> (state_r == S_DONE && !mreq_r.req
      && ea_r == $past(word_r.addr)) ##1 res_valid_r)
    else $error("plain pointer did not end chain with its address");

  AST_STEPUP_WB: assert property ( // R04
    (in_mod && cur_td == TD_STEP_UP) |=> (mreq_r.we && ea_r == $past(word_r.addr)
      && mreq_r.wdata.addr == ADDR_W'($past(word_r.addr) + ADDR_ONE)
      && mreq_r.wdata.tally == TALLY_W'($past(word_r.tally) - TALLY_ONE)))
    else $error("step-up write back wrong");

  AST_RUNOUT: assert property ( // R05
    (in_mod && upd_wr && upd_word.tally == TALLY_ZERO) |=> tally_runout)
    else $error("runout not set at zero tally");

  AST_STEPDOWN_EA: assert property ( // R06
    (in_mod && cur_td == TD_STEP_DOWN) |=>
      (ea_r == ADDR_W'($past(word_r.addr) - ADDR_ONE) && ea_r == mreq_r.wdata.addr))
    else $error("step-down address not pre-decremented");

  AST_SEQ_WRAP: assert property ( // R09
    (in_mod && cur_td == TD_SEQ_CHAR && word_r.tag[CPOS_W-1:0] == CPOS_LAST) |=>
      (mreq_r.wdata.tag[CPOS_W-1:0] == CPOS_FIRST
      && mreq_r.wdata.addr == ADDR_W'($past(word_r.addr) + ADDR_ONE)))
    else $error("character position did not wrap");

  AST_CHAR_NOWRITE: assert property ( // R10
    (in_mod && cur_td == TD_CHAR_PTR) |=> (!mreq_r.req && char_valid_r
      && char_r == $past(word_r.tag[CPOS_W-1:0])))
    else $error("fixed character pointer modified");

  AST_TRAP: assert property ( // R12
    (in_mod && cur_td == TD_TRAP) |=> (ea_r == FAULT_LOC && fault_r && !mreq_r.req)
      ##1 (res_valid_r && res_fault))
    else $error("trap did not force fault transfer");

  AST_WB_FIRST: assert property ( // R19
    (state_r == S_WBACK && !mem_ack) |=> (!res_valid_r && mreq_r.req && mreq_r.we))
    else $error("result given before pointer write back");
endmodule

// [taa_mem_model.sv]
// Main memory partner that holds pointer words for the modifier
`timescale 1ns/100ps
module taa_mem_model
  import taa_pkg::*;
(
  // Clock and reset
  input  wire logic               mclk,
  input  wire logic               rst,
  // Modifier side
  input  wire taa_pkg::taa_mreq_t mem_out,
  input  wire logic [3:0]         wait_cyc,
  output logic                    mem_ack,
  output taa_pkg::taa_word_t      mem_rdata
);
  taa_word_t  mem [256];
  logic [3:0] cnt_r;

  // Plain always: the bench preloads words between instructions
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      mem_ack   <= 1'b0;
      cnt_r     <= 4'h0;
      mem_rdata <= '0;
    end else if (mem_out.req && !mem_ack && cnt_r == wait_cyc) begin
      mem_ack <= 1'b1;
      cnt_r   <= 4'h0;
      if (mem_out.we)
        mem[mem_out.addr[7:0]] <= mem_out.wdata;
      else
        mem_rdata <= mem[mem_out.addr[7:0]];
    end else begin
      // Read data is not held past the answer, so a late sample shows
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
      cnt_r     <= (mem_out.req && !mem_ack) ? cnt_r + 4'h1 : 4'h0;
    end
  end
endmodule

// [taa_modifier_bench.sv]
// Self-checking bench for the tally address modifier
`timescale 1ns/100ps
module taa_modifier_bench;
  import taa_pkg::*;
  localparam logic [ADDR_W-1:0] FLOC = 18'h00777;
  localparam logic [ADDR_W-1:0] B    = 18'h00040;
  localparam logic [ADDR_W-1:0] PL   = 18'h00010;
  localparam logic [ADDR_W-1:0] C    = 18'h00088;
  localparam logic [ADDR_W-1:0] E    = 18'h000aa;
  logic                mclk, rst, inst_valid, inst_ready, res_valid;
  logic                res_char_valid, res_fault, tally_runout, mem_ack;
  logic                psel, penable, pwrite, pready, pslverr, irq;
  logic                cv, flt, perr;
  logic [ADDR_W-1:0]   inst_y, res_ea, ea;
  logic [TAG_W-1:0]    inst_tag;
  logic [CPOS_W-1:0]   res_char, ch;
  logic [APB_AW-1:0]   paddr;
  logic [31:0]         pwdata, prdata, rd;
  logic [3:0]          wait_cyc;
  taa_mreq_t           mem_out;
  taa_word_t           mem_rdata;
  int                  error_cnt, samples_checked;

  taa_modifier #(.FAULT_LOC(FLOC)) taa_modifier_i (
    .mclk, .rst, .inst_valid, .inst_y, .inst_tag, .inst_ready, .res_valid, .res_ea,
    .res_char, .res_char_valid, .res_fault, .tally_runout, .mem_out, .mem_ack,
    .mem_rdata, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .irq);
  taa_mem_model taa_mem_model_i (
    .mclk, .rst, .mem_out, .wait_cyc, .mem_ack, .mem_rdata);

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic cmp(input logic [35:0] got, input logic [35:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [APB_AW-1:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // No cycle limit here: the watchdog ends this wait only if pready never comes
    do @(posedge mclk); while (pready !== 1'b1);
    rd   = prdata;
    perr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Hold the request until taken, then wait for the one-cycle result
  task automatic op(input logic [ADDR_W-1:0] y, input logic [TAG_W-1:0] t);
    int n;
    n = 0;
    @(posedge mclk);
    inst_valid <= 1'b1;
    inst_y     <= y;
    inst_tag   <= t;
    do begin
      @(posedge mclk);
      n++;
    end while (inst_ready !== 1'b1 && n < 50);
    inst_valid <= 1'b0;
    do begin
      @(posedge mclk);
      n++;
    end while (res_valid !== 1'b1 && n < 200);
    cmp(res_valid, 1, "result");
    ea  = res_ea;
    ch  = res_char;
    cv  = res_char_valid;
    flt = res_fault;
  endtask

  task automatic t_regs;
    apb(1'b0, OFF_MASK, 0);
    cmp(rd, 32'h0, "mask reset");
    apb(1'b0, OFF_CTRL, 0);
    cmp(rd, 32'h1, "ctrl reset");
    apb(1'b0, 12'h010, 0);
    cmp(perr, 1, "unmapped");
    apb(1'b1, OFF_CTRL, 0);
    repeat (2) @(posedge mclk);
    cmp(inst_ready, 0, "disabled");
    apb(1'b1, OFF_CTRL, 1);
  endtask

  task automatic t_noreg(input logic [TAG_W-1:0] t);
    taa_mem_model_i.mem[PL] = {B, 12'h003, 6'h00};
    op(PL, t);
    cmp(ea, B, "no offset");
    cmp(flt, 0, "no fault");
    apb(1'b0, OFF_EA, 0);
    cmp(rd, {14'h0, B}, "ea register");
  endtask

  task automatic t_plain;
    taa_mem_model_i.mem[PL] = {B, 12'h003, 6'h2e};
    op(PL, TAG_IT_PLAIN);
    cmp(ea, B, "plain ea");
    cmp(taa_mem_model_i.mem[PL], {B, 12'h003, 6'h2e}, "plain word");
  endtask

  // Two references; tally starts so that the second one runs out
  task automatic t_walk(input logic [3:0] td, input int dlt, input logic [5:0] g);
    logic [11:0] t0;
    int          pre;
    pre = (dlt < 0);
    t0  = pre ? 12'hffe : 12'h002;
    taa_mem_model_i.mem[PL] = {B, t0, g};
    for (int k = 0; k < 2; k++) begin
      op(PL, {TM_IT, td});
      cmp(ea, 18'(B + dlt * (k + pre)), "step ea");
      apb(1'b0, OFF_STAT, 0);
      cmp(rd[SB_RUNOUT], k, "runout");
    end
    cmp(taa_mem_model_i.mem[PL], {18'(B + 2 * dlt), 12'h000, g}, "step word");
  endtask

  task automatic t_seq;
    taa_mem_model_i.mem[PL] = {B, 12'h003, 6'h04};
    for (int k = 0; k < 3; k++) begin
      op(PL, {TM_IT, TD_SEQ_CHAR});
      cmp(ea, B + (k == 2), "seq ea");
      cmp({cv, ch}, (k == 2) ? 4'h8 : 4'hc + k, "seq char");
    end
    cmp(taa_mem_model_i.mem[PL], {B + 18'h1, 12'h000, 6'h01}, "seq word");
    apb(1'b0, OFF_STAT, 0);
    cmp(rd[SB_RUNOUT], 1, "seq runout");
  endtask

  task automatic t_fixed(input logic [3:0] td, input logic [ADDR_W-1:0] xea);
    taa_mem_model_i.mem[PL] = {B, 12'h003, 6'h03};
    op(PL, {TM_IT, td});
    cmp(ea, xea, "fixed ea");
    cmp(flt, td == TD_TRAP, "fault flag");
    if (td == TD_CHAR_PTR)
      cmp({cv, ch}, 4'hb, "fixed char");
    cmp(taa_mem_model_i.mem[PL], {B, 12'h003, 6'h03}, "fixed word");
    apb(1'b0, OFF_STAT, 0);
    cmp(rd[SB_FAULT], td == TD_TRAP, "fault bit");
  endtask

  // Targets carry register forms with no register only
  task automatic t_chain;
    taa_mem_model_i.mem[PL]     = {B, 12'h005, 6'h00};
    taa_mem_model_i.mem[B]      = {C, 12'h000, 6'h00};
    taa_mem_model_i.mem[B + 1]  = {E, 12'h000, 6'h00};
    op(PL, {TM_IT, TD_UP_CHAIN});
    cmp(ea, C, "up chain ea");
    cmp(taa_mem_model_i.mem[PL], {B + 18'h1, 12'h004, 6'h00}, "up chain word");
    op(PL, {TM_IT, TD_DOWN_CHAIN});
    cmp(ea, C, "down chain ea");
    cmp(taa_mem_model_i.mem[PL], {B, 12'h005, 6'h00}, "down chain word");
  endtask

  task automatic t_irq;
    apb(1'b1, OFF_MASK, 32'h1 << SB_RUNOUT);
    taa_mem_model_i.mem[PL] = {B, 12'h001, 6'h00};
    op(PL, {TM_IT, TD_STEP_UP});
    @(posedge mclk);
    cmp({irq, tally_runout}, 2'b11, "irq raised");
    apb(1'b0, OFF_STAT, 0);
    repeat (2) @(posedge mclk);
    cmp({irq, tally_runout}, 2'b00, "irq cleared");
    apb(1'b1, OFF_MASK, 0);
    taa_mem_model_i.mem[PL] = {B, 12'h001, 6'h00};
    op(PL, {TM_IT, TD_STEP_UP});
    @(posedge mclk);
    cmp({irq, tally_runout}, 2'b01, "irq masked");
  endtask

  task automatic conclude;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    rst        = 1'b1;
    inst_valid = 1'b0;
    inst_y     = '0;
    inst_tag   = '0;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = '0;
    pwdata     = '0;
    wait_cyc   = 4'h0;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    t_regs;
    t_noreg(TAG_REG_PTR_NONE);
    t_noreg(TAG_PTR_IDX_NONE);
    t_plain;
    wait_cyc <= 4'h3;
    t_walk(TD_STEP_UP, 1, 6'h00);
    t_walk(TD_STEP_DOWN, -1, 6'h00);
    t_walk(TD_STRIDE, 5, 6'h05);
    wait_cyc <= 4'h0;
    t_seq;
    t_fixed(TD_CHAR_PTR, B);
    t_fixed(TD_TRAP, FLOC);
    t_chain;
    t_irq;
    conclude;
  end

  // Whole run needs a few hundred cycles; this bound of 20000 cycles is far past it
  initial begin
    #200000;
    error_cnt++;
    conclude;
  end
endmodule
